// ---- rtl/acd_pkg.sv ----
// Package: register offsets, field positions, command codes and decode types.
// Assumes a byte-wide task-file register port on the sys_clk domain.
package acd_pkg;

   // ****************************************
   // Register offsets and field positions
   // ****************************************
   localparam logic [3:0] ACD_OFS_FEATURES = 4'h1;
   localparam logic [3:0] ACD_OFS_SECTOR_COUNT = 4'h2;
   localparam logic [3:0] ACD_OFS_DRIVE_HEAD = 4'h6;
   localparam logic [3:0] ACD_OFS_COMMAND = 4'h7;
   localparam logic [3:0] ACD_OFS_DEVICE_CONTROL = 4'hE;
   localparam logic [3:0] ACD_OFS_DRIVE_ADDRESS = 4'hF;
   localparam int ACD_CTL_SRST_BIT = 2;
   localparam int ACD_CTL_IEN_BIT = 1;
   localparam int ACD_DH_DRV_BIT = 4;
   localparam int ACD_DH_HEAD_MSB = 3;
   localparam int ACD_DA_WTG_BIT = 6;
   localparam int ACD_DA_HEAD_MSB = 5;
   localparam int ACD_DA_HEAD_LSB = 2;
   localparam int ACD_DA_DS1_BIT = 1;
   localparam int ACD_DA_DS0_BIT = 0;
   localparam logic ACD_IEN_RESET = 1'b0;
   localparam logic [7:0] ACD_ZERO_BYTE = 8'h00;
   localparam logic [3:0] ACD_ZERO_NIB = 4'h0;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] ACD_CMD_KEY_MGMT = 8'hB9;
   localparam logic [7:0] ACD_CMD_WR_MULT_NOERASE = 8'hCD;
   localparam logic [7:0] ACD_CMD_WR_SECT_NOERASE = 8'h38;
   localparam logic [7:0] ACD_FEAT_READ_KEYING = 8'h80;
   localparam logic [7:0] ACD_FEAT_CHANGE_KEY = 8'h81;
   localparam logic [7:0] ACD_FEAT_STRUCT_MAX = 8'h7F;

   // ****************************************
   // Timing
   // ****************************************
   localparam int ACD_REINIT_NS = 2000;
   localparam int ACD_CLK_NS = 20;
   localparam int ACD_REINIT_CYC = (ACD_REINIT_NS + ACD_CLK_NS - 1) / ACD_CLK_NS;
   localparam int ACD_CNT_W = 8;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      ACD_CLASS_NONE = 2'b00,
      ACD_CLASS_1 = 2'b01,
      ACD_CLASS_2 = 2'b10,
      ACD_CLASS_3 = 2'b11
   } acd_class_type;

   typedef enum logic [1:0] {
      ACD_DH_NONE = 2'b00,
      ACD_DH_DRIVE = 2'b01,
      ACD_DH_FULL = 2'b10
   } acd_dh_use_type;

   typedef struct packed {
      logic valid;
      acd_class_type cls;
      logic uses_features;
      logic uses_count;
      logic uses_number;
      logic uses_cylinder;
      acd_dh_use_type dh_use;
      logic lba_ok;
   } acd_decode_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] data;
   } acd_bus_type;

endpackage : acd_pkg

// ---- rtl/acd_decoder.sv ----
// Command decoder: maps code and features to class and parameter use.
// Assumes purely combinational use inside the control block.
module acd_decoder
   import acd_pkg::*;
(
   input wire logic [7:0] code,
   input wire logic [7:0] features,
   output acd_decode_type dec
);

   // ****************************************
   // Table lookup
   // ****************************************
   function automatic acd_decode_type mk(input acd_class_type c, input logic f, input logic s,
                                         input logic n, input logic y, input acd_dh_use_type h,
                                         input logic l);
      mk = '{1'b1, c, f, s, n, y, h, l};
   endfunction

   always_comb begin
      dec = '{1'b0, ACD_CLASS_NONE, 1'b0, 1'b0, 1'b0, 1'b0, ACD_DH_NONE, 1'b0};
      case (code) // [RULE_14]
         8'hE5, 8'h98, 8'h90, 8'hE7, 8'hEC, 8'hE1, 8'h95, 8'h00, 8'hE4, 8'h03,
         8'hF6, 8'hF3, 8'hF4, 8'hF5, 8'hF1, 8'hF2, 8'hE6, 8'h99, 8'hE2, 8'h96,
         8'hE0, 8'h94:
            dec = mk(ACD_CLASS_1, 1'b0, 1'b0, 1'b0, 1'b0, ACD_DH_DRIVE, 1'b0);
         8'hE3, 8'h97, 8'hC6:
            dec = mk(ACD_CLASS_1, 1'b0, 1'b1, 1'b0, 1'b0, ACD_DH_DRIVE, 1'b0);
         8'hEF:
            dec = mk(ACD_CLASS_1, 1'b1, 1'b0, 1'b0, 1'b0, ACD_DH_DRIVE, 1'b0);
         8'h91:
            dec = mk(ACD_CLASS_1, 1'b0, 1'b1, 1'b0, 1'b0, ACD_DH_FULL, 1'b0);
         8'hC0, 8'hC8, 8'hC4, 8'h20, 8'h21, 8'h40, 8'h41, 8'h87:
            dec = mk(ACD_CLASS_1, 1'b0, 1'b1, 1'b1, 1'b1, ACD_DH_FULL, 1'b1);
         8'h22, 8'h23:
            dec = mk(ACD_CLASS_1, 1'b0, 1'b0, 1'b1, 1'b1, ACD_DH_FULL, 1'b1);
         8'h50:
            dec = mk(ACD_CLASS_2, 1'b0, 1'b1, 1'b0, 1'b1, ACD_DH_FULL, 1'b1);
         8'hE8:
            dec = mk(ACD_CLASS_2, 1'b0, 1'b0, 1'b0, 1'b0, ACD_DH_DRIVE, 1'b0);
         8'hCA, 8'h30, 8'h31, ACD_CMD_WR_SECT_NOERASE: // [RULE_16]
            dec = mk(ACD_CLASS_2, 1'b0, 1'b1, 1'b1, 1'b1, ACD_DH_FULL, 1'b1);
         8'h32, 8'h33:
            dec = mk(ACD_CLASS_2, 1'b0, 1'b0, 1'b1, 1'b1, ACD_DH_FULL, 1'b1);
         8'hC5, ACD_CMD_WR_MULT_NOERASE, 8'h3C: // [RULE_15]
            dec = mk(ACD_CLASS_3, 1'b0, 1'b1, 1'b1, 1'b1, ACD_DH_FULL, 1'b1);
         ACD_CMD_KEY_MGMT: begin
            if (features == ACD_FEAT_CHANGE_KEY) begin // [RULE_17]
               dec = mk(ACD_CLASS_2, 1'b1, 1'b1, 1'b1, 1'b1, ACD_DH_FULL, 1'b0);
            end else if (features == ACD_FEAT_READ_KEYING) begin // [RULE_18]
               dec = mk(ACD_CLASS_1, 1'b1, 1'b1, 1'b1, 1'b1, ACD_DH_FULL, 1'b0);
            end else if (features <= ACD_FEAT_STRUCT_MAX) begin // [RULE_19]
               dec = mk(ACD_CLASS_1, 1'b1, 1'b1, 1'b1, 1'b1, ACD_DH_FULL, 1'b0);
            end
         end
         default: begin
            if (code[7:4] == 4'h1) begin
               dec = mk(ACD_CLASS_1, 1'b0, 1'b0, 1'b0, 1'b0, ACD_DH_DRIVE, 1'b0);
            end else if (code[7:4] == 4'h7) begin
               dec = mk(ACD_CLASS_1, 1'b0, 1'b0, 1'b1, 1'b1, ACD_DH_FULL, 1'b1);
            end
         end
      endcase
   end

endmodule // acd_decoder

// ---- rtl/acd_control.sv ----
// Task-file control, drive address readback and command acceptance.
// Assumes a synchronous byte register port on sys_clk from the host interface.
//
// What this block does
// [RULE_01] Control register writable even while busy
// [RULE_02] Soft reset held while bit two set
// [RULE_03] Soft reset leaves configuration registers intact
// [RULE_04] Interrupt disable bit suppresses interrupt request
// [RULE_05] Same bit gates configuration status flag
// [RULE_06] Interrupt disable cleared on reset
// [RULE_07] Other control bits ignored on write
// [RULE_08] Write gate reads zero during writes
// [RULE_09] Readback bits show inverted head bits
// [RULE_10] Drive select readback bits active low
// [RULE_11] Host preferably leaves readback register unmapped
// [RULE_12] Host writes parameters first, command last
// [RULE_13] Host issues commands only when not busy
// [RULE_14] Every code decoded into acceptance class
// [RULE_15] Code CD is class three
// [RULE_16] Code 38 is class two
// [RULE_17] Key opcode feature 81 is class two
// [RULE_18] Key opcode feature 80 is class one
// [RULE_19] Key opcode features 0-127 structure read
// [RULE_20] Full drive/head use includes head bits
// [RULE_21] Busy flag locks host out
// [RULE_22] Drive bit compared with configured number
// [RULE_23] Unknown code aborts and interrupts
// [RULE_24] Busy during reinitialisation after soft reset
module acd_control
   import acd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input acd_bus_type bus,
   input wire logic drive_number,
   input wire logic write_in_progress,
   input wire logic cmd_done,
   input wire logic cmd_error,
   output logic [7:0] read_data,
   output logic busy_flag,
   output logic ready_flag,
   output logic error_flag,
   output logic abort_flag,
   output logic intrq,
   output logic config_int_flag,
   output logic soft_reset_active,
   output logic cmd_start,
   output logic [7:0] cmd_code,
   output acd_decode_type cmd_decode,
   output logic [3:0] cmd_head
);

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {
      ACD_ST_IDLE = 2'b00,
      ACD_ST_SRST = 2'b01,
      ACD_ST_REINIT = 2'b10,
      ACD_ST_EXEC = 2'b11
   } acd_state_type;

   acd_state_type state_q, state_d;
   logic srst_q, srst_d;
   logic ien_n_q, ien_n_d;
   logic [7:0] features_q, features_d;
   logic [7:0] drive_head_q, drive_head_d;
   logic [ACD_CNT_W-1:0] cnt_q, cnt_d;
   logic pend_q, pend_d;
   logic err_q, err_d;
   logic abrt_q, abrt_d;
   logic start_q, start_d;
   logic [7:0] code_q, code_d;
   acd_decode_type dec_q, dec_d;
   logic [3:0] head_q, head_d;
   logic [7:0] rdata_q, rdata_d;
   logic wip_s1_q, wip_s2_q, wip_s3_q, wip_q, wip_d;
   acd_decode_type dec_now;
   logic selected;

   acd_decoder u_decoder (
      .code(bus.data),
      .features(features_q),
      .dec(dec_now)
   );

   // Drive match against configured number
   assign selected = (drive_head_q[ACD_DH_DRV_BIT] == drive_number); // [RULE_22]

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_d = state_q;
      srst_d = srst_q;
      ien_n_d = ien_n_q;
      features_d = features_q;
      drive_head_d = drive_head_q;
      cnt_d = cnt_q;
      pend_d = pend_q;
      err_d = err_q;
      abrt_d = abrt_q;
      start_d = 1'b0;
      code_d = code_q;
      dec_d = dec_q;
      head_d = head_q;
      wip_d = (wip_s2_q == wip_s3_q) ? wip_s2_q : wip_q;
      // Control register honoured in any state
      if (bus.wr && bus.addr == ACD_OFS_DEVICE_CONTROL) begin // [RULE_01]
         srst_d = bus.data[ACD_CTL_SRST_BIT]; // [RULE_02] [RULE_07]
         ien_n_d = bus.data[ACD_CTL_IEN_BIT]; // [RULE_04]
      end
      if (bus.wr && state_q == ACD_ST_IDLE) begin // [RULE_21]
         if (bus.addr == ACD_OFS_FEATURES) begin
            features_d = bus.data;
         end
         if (bus.addr == ACD_OFS_DRIVE_HEAD) begin
            drive_head_d = bus.data;
         end
      end
      if (bus.rd && bus.addr == ACD_OFS_COMMAND) begin
         pend_d = 1'b0;
      end
      unique case (state_q)
         ACD_ST_IDLE: begin
            if (bus.wr && bus.addr == ACD_OFS_COMMAND && selected && !srst_d) begin
               err_d = 1'b0;
               abrt_d = 1'b0;
               code_d = bus.data;
               dec_d = dec_now;
               head_d = (dec_now.dh_use == ACD_DH_FULL) ? drive_head_q[3:0] :
                        ACD_ZERO_NIB; // [RULE_20]
               if (dec_now.valid) begin // [RULE_14]
                  start_d = 1'b1;
                  state_d = ACD_ST_EXEC;
               end else begin
                  err_d = 1'b1; // [RULE_23]
                  abrt_d = 1'b1;
                  pend_d = 1'b1;
               end
            end
         end
         ACD_ST_EXEC: begin
            if (cmd_done) begin
               err_d = cmd_error;
               pend_d = 1'b1;
               state_d = ACD_ST_IDLE;
            end
         end
         ACD_ST_SRST: begin
            if (!srst_q) begin
               cnt_d = ACD_CNT_W'(ACD_REINIT_CYC); // [RULE_24]
               state_d = ACD_ST_REINIT;
            end
         end
         ACD_ST_REINIT: begin
            if (cnt_q == ACD_CNT_W'(1)) begin
               state_d = ACD_ST_IDLE;
            end
            cnt_d = cnt_q - ACD_CNT_W'(1);
         end
      endcase
      // Soft reset clears only the controller, not the config side
      if (srst_q) begin // [RULE_02] [RULE_03]
         state_d = ACD_ST_SRST;
         pend_d = 1'b0;
         err_d = 1'b0;
         abrt_d = 1'b0;
         start_d = 1'b0;
      end
   end

   // Readback
   always_comb begin
      rdata_d = ACD_ZERO_BYTE;
      if (bus.rd && bus.addr == ACD_OFS_DRIVE_ADDRESS) begin
         rdata_d[ACD_DA_WTG_BIT] = ~wip_q; // [RULE_08]
         rdata_d[ACD_DA_HEAD_MSB:ACD_DA_HEAD_LSB] = ~drive_head_q[ACD_DH_HEAD_MSB:0]; // [RULE_09]
         rdata_d[ACD_DA_DS1_BIT] = ~(drive_head_q[ACD_DH_DRV_BIT] && drive_number); // [RULE_10]
         rdata_d[ACD_DA_DS0_BIT] = ~(!drive_head_q[ACD_DH_DRV_BIT] && !drive_number);
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= ACD_ST_REINIT;
         srst_q <= 1'b0;
         ien_n_q <= ACD_IEN_RESET; // [RULE_06]
         features_q <= ACD_ZERO_BYTE;
         drive_head_q <= ACD_ZERO_BYTE;
         cnt_q <= ACD_CNT_W'(ACD_REINIT_CYC);
         pend_q <= 1'b0;
         err_q <= 1'b0;
         abrt_q <= 1'b0;
         start_q <= 1'b0;
         code_q <= ACD_ZERO_BYTE;
         dec_q <= '0;
         head_q <= ACD_ZERO_NIB;
         rdata_q <= ACD_ZERO_BYTE;
         wip_s1_q <= 1'b0;
         wip_s2_q <= 1'b0;
         wip_s3_q <= 1'b0;
         wip_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         srst_q <= srst_d;
         ien_n_q <= ien_n_d;
         features_q <= features_d;
         drive_head_q <= drive_head_d;
         cnt_q <= cnt_d;
         pend_q <= pend_d;
         err_q <= err_d;
         abrt_q <= abrt_d;
         start_q <= start_d;
         code_q <= code_d;
         dec_q <= dec_d;
         head_q <= head_d;
         rdata_q <= rdata_d;
         wip_s1_q <= write_in_progress;
         wip_s2_q <= wip_s1_q;
         wip_s3_q <= wip_s2_q;
         wip_q <= wip_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic intrq_q, intrq_d, cfg_int_q, cfg_int_d;
   logic busy_q, busy_d, ready_q, ready_d, sra_q, sra_d;

   // Status flags follow the next state, so they line up with state_q
   always_comb begin
      intrq_d = pend_d && !ien_n_d; // [RULE_04] [RULE_23]
      cfg_int_d = pend_d && !ien_n_d; // [RULE_05]
      busy_d = (state_d != ACD_ST_IDLE); // [RULE_21]
      ready_d = (state_d == ACD_ST_IDLE);
      sra_d = (state_d == ACD_ST_SRST);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         intrq_q <= 1'b0;
         cfg_int_q <= 1'b0;
         busy_q <= 1'b1;
         ready_q <= 1'b0;
         sra_q <= 1'b0;
      end else if (clk_en) begin
         intrq_q <= intrq_d;
         cfg_int_q <= cfg_int_d;
         busy_q <= busy_d;
         ready_q <= ready_d;
         sra_q <= sra_d;
      end
   end

   assign read_data = rdata_q;
   assign busy_flag = busy_q; // [RULE_21]
   assign ready_flag = ready_q;
   assign error_flag = err_q;
   assign abort_flag = abrt_q;
   assign intrq = intrq_q;
   assign config_int_flag = cfg_int_q;
   assign soft_reset_active = sra_q;
   assign cmd_start = start_q;
   assign cmd_code = code_q;
   assign cmd_decode = dec_q;
   assign cmd_head = head_q;

   // ****************************************
   // Checks
   // ****************************************
   srst_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_02]
      clk_en && srst_q ##1 clk_en |-> state_q == ACD_ST_SRST)
      else $error("soft reset not held");
   ien_gate_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_04]
      ien_n_q |-> !intrq)
      else $error("interrupt not suppressed");
   ien_reset_a: assert property (@(posedge sys_clk) // [RULE_06]
      reset |=> !ien_n_q && !intrq)
      else $error("interrupt disable not cleared by reset");
   ctl_ien_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_04]
      clk_en && bus.wr && bus.addr == ACD_OFS_DEVICE_CONTROL |=>
      ien_n_q == $past(bus.data[ACD_CTL_IEN_BIT]))
      else $error("interrupt disable write lost");
   dh_lock_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_21]
      clk_en && busy_flag && bus.wr && bus.addr == ACD_OFS_DRIVE_HEAD |=>
      drive_head_q == $past(drive_head_q))
      else $error("drive head written while busy");
   cfg_gate_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_05]
      intrq == config_int_flag)
      else $error("config flag differs from interrupt");
   ctl_busy_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_01]
      clk_en && bus.wr && bus.addr == ACD_OFS_DEVICE_CONTROL |=>
      srst_q == $past(bus.data[ACD_CTL_SRST_BIT]))
      else $error("control write lost");
   reinit_busy_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_24]
      $fell(soft_reset_active) |-> busy_flag)
      else $error("not busy after soft reset");
   head_use_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_20]
      cmd_start && cmd_decode.dh_use != ACD_DH_FULL |-> cmd_head == ACD_ZERO_NIB)
      else $error("head bits used for drive-only command");
   abort_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_23]
      abort_flag |-> error_flag && !busy_flag)
      else $error("abort without error");
   start_class_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_14]
      cmd_start |-> cmd_decode.valid && cmd_decode.cls != ACD_CLASS_NONE && busy_flag)
      else $error("started command without class");
   wg_read_a: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
      clk_en && bus.rd && bus.addr == ACD_OFS_DRIVE_ADDRESS |=> read_data[6] == !$past(wip_q))
      else $error("write gate readback wrong");

endmodule // acd_control

// ---- test/acd_exec_model.sv ----
// Command executor model standing behind the control block.
// Assumes cmd_start pulses once per accepted command on sys_clk.
module acd_exec_model
   import acd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic cmd_start,
   input acd_decode_type cmd_decode,
   input wire logic [31:0] delay,
   input wire logic fail,
   output logic cmd_done,
   output logic cmd_error,
   output logic write_in_progress
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial begin
      cmd_done = 1'b0;
      cmd_error = 1'b0;
      write_in_progress = 1'b0;
   end
   // ****************************************
   // Prompt or slow completion
   // ****************************************
   always @(posedge sys_clk) begin
      cmd_done <= 1'b0;
      cmd_error <= ~cmd_error;
      if (reset) begin
         cnt <= 0;
         write_in_progress <= 1'b0;
      end else if (cmd_start) begin
         cnt <= int'(delay);
         write_in_progress <= cmd_decode.cls[1];
      end else if (cnt == 1) begin
         cnt <= 0;
         cmd_done <= 1'b1;
         cmd_error <= fail;
         write_in_progress <= 1'b0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule // acd_exec_model

// ---- test/tb.sv ----
// Self-checking bench for the task-file control block.
// Assumes the executor model answers every accepted command that soft reset does not cut off.
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin fail_count++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
   import acd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [1:0] kind;
      logic [7:0] v;
      logic [1:0] cls;
      logic [3:0] head;
   } acd_exp_type;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   acd_bus_type bus = '0;
   logic drive_number = 1'b0;
   logic write_in_progress, cmd_done, cmd_error, fail = 1'b0;
   logic [7:0] read_data, cmd_code;
   logic busy_flag, ready_flag, error_flag, abort_flag, intrq, config_int_flag;
   logic soft_reset_active, cmd_start, ab_q = 1'b0, rd_seen = 1'b0, ien_off = 1'b0;
   acd_decode_type cmd_decode;
   logic [3:0] cmd_head;
   int delay = 4, fail_count = 0, cmp_count = 0, seed = 32'h00F1F63B;
   logic [7:0] dh;
   acd_exp_type q[$];
   acd_exp_type e;

   acd_control dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .bus(bus),
      .drive_number(drive_number), .write_in_progress(write_in_progress),
      .cmd_done(cmd_done), .cmd_error(cmd_error), .read_data(read_data),
      .busy_flag(busy_flag), .ready_flag(ready_flag), .error_flag(error_flag),
      .abort_flag(abort_flag), .intrq(intrq), .config_int_flag(config_int_flag),
      .soft_reset_active(soft_reset_active), .cmd_start(cmd_start), .cmd_code(cmd_code),
      .cmd_decode(cmd_decode), .cmd_head(cmd_head));
   acd_exec_model model (.sys_clk(sys_clk), .reset(reset | soft_reset_active),
      .cmd_start(cmd_start), .cmd_decode(cmd_decode), .delay(delay), .fail(fail),
      .cmd_done(cmd_done), .cmd_error(cmd_error), .write_in_progress(write_in_progress));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   // ****************************************
   // Result monitor
   // ****************************************
   task automatic take(input acd_exp_type g);
      if (q.size() == 0) begin
         `CHK("unexpected result", 16'h0000, g)
      end else begin
         e = q.pop_front();
         `CHK("result", e, g)
      end
   endtask
   always @(posedge sys_clk) begin
      if (rd_seen) take({2'd1, read_data & 8'h7F, 2'd0, 4'h0});
      if (cmd_start === 1'b1) take({2'd0, cmd_code, cmd_decode.cls, cmd_head});
      if (abort_flag === 1'b1 && ab_q === 1'b0) take({2'd2, 7'h00, error_flag, 6'h00});
      ab_q <= abort_flag;
      rd_seen <= bus.rd && clk_en && bus.addr == ACD_OFS_DRIVE_ADDRESS;
   end
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      bus = '{1'b1, 1'b0, a, d};
      @(negedge sys_clk);
      bus.wr = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] x);
      @(negedge sys_clk);
      bus = '{1'b0, 1'b1, a, 8'h00};
      if (a == ACD_OFS_DRIVE_ADDRESS) q.push_back({2'd1, x, 2'd0, 4'h0});
      @(negedge sys_clk);
      bus.rd = 1'b0;
   endtask
   function automatic logic [7:0] rb(input logic [7:0] h, input logic w);
      logic s;
      s = (h[ACD_DH_DRV_BIT] == drive_number);
      return {1'b0, ~w, ~h[3:0], ~(s & drive_number), ~(s & ~drive_number)};
   endfunction
   task automatic wait_idle();
      int i;
      for (i = 0; i < 400 && !(ready_flag === 1'b1 && busy_flag === 1'b0); i++) @(negedge sys_clk);
      `CHK("idle", 1'b1, ready_flag & ~busy_flag)
   endtask
   task automatic clr();
      rd(ACD_OFS_COMMAND, 8'h00);
      `CHK("intrq cleared", 1'b0, intrq)
   endtask
   task automatic cmd(input logic [7:0] c, f, input logic [1:0] k, input logic full, ok);
      dh = {3'b101, drive_number, 4'($random(seed))};
      wr(ACD_OFS_FEATURES, f);
      wr(ACD_OFS_DRIVE_HEAD, dh);
      if (ok) q.push_back({2'd0, c, k, full ? dh[3:0] : 4'h0});
      else q.push_back({2'd2, 7'h00, 1'b1, 6'h00});
      wr(ACD_OFS_COMMAND, c);
      wait_idle();
      @(negedge sys_clk);
      `CHK("intrq", ~ien_off, intrq)
      `CHK("config int", ~ien_off, config_int_flag)
   endtask
   task automatic end_of_test();
      if (q.size() != 0) fail_count++;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #(20 * 20000);
      fail_count++;
      end_of_test();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      logic [7:0] t[10][4];
      int i;
      t = '{'{8'hCD, 8'h00, 3, 1}, '{8'h38, 8'h00, 2, 1}, '{8'hB9, 8'h81, 2, 1},
         '{8'hB9, 8'h80, 1, 1}, '{8'h02, 8'h00, 0, 0}, '{8'hB9, 8'h05, 1, 1},
         '{8'hEC, 8'h00, 1, 0}, '{8'hC5, 8'h00, 3, 1}, '{8'h30, 8'h00, 2, 1},
         '{8'hB9, 8'h90, 0, 0}};
      repeat (10) @(negedge sys_clk);
      reset = 1'b0;
      wait_idle();
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         drive_number = 1'($random(seed));
         dh = 8'($random(seed));
         wr(ACD_OFS_DRIVE_HEAD, dh);
         rd(ACD_OFS_DRIVE_ADDRESS, rb(dh, 1'b0) & 8'h7F);
      end
      $display("test readback done");
      for (i = 0; i < 10; i++) begin
         cmd(t[i][0], t[i][1], t[i][2][1:0], t[i][3][0], |t[i][2]);
         clr();
      end
      $display("test decode done");
      wr(ACD_OFS_DRIVE_HEAD, {3'b101, ~drive_number, 4'h3});
      wr(ACD_OFS_COMMAND, 8'hEC);
      repeat (5) @(negedge sys_clk);
      `CHK("other drive busy", 1'b0, busy_flag)
      wr(ACD_OFS_DRIVE_HEAD, {3'b101, drive_number, 4'h3});
      @(negedge sys_clk);
      clk_en = 1'b0;
      wr(ACD_OFS_COMMAND, 8'hEC);
      clk_en = 1'b1;
      repeat (3) @(negedge sys_clk);
      `CHK("frozen busy", 1'b0, busy_flag)
      $display("test ignore done");
      ien_off = 1'b1;
      fail = 1'b1;
      wr(ACD_OFS_DEVICE_CONTROL, 8'h02);
      cmd(8'hEC, 8'h00, 1, 0, 1);
      `CHK("error", 1'b1, error_flag)
      fail = 1'b0;
      ien_off = 1'b0;
      wr(ACD_OFS_DEVICE_CONTROL, 8'hF9);
      @(negedge sys_clk);
      `CHK("intrq enabled", 1'b1, intrq)
      `CHK("no soft reset", 1'b0, soft_reset_active)
      clr();
      $display("test interrupt done");
      delay = 30;
      dh = {3'b101, drive_number, 4'hA};
      wr(ACD_OFS_DRIVE_HEAD, dh);
      q.push_back({2'd0, 8'h38, 2'd2, 4'hA});
      wr(ACD_OFS_COMMAND, 8'h38);
      repeat (8) @(negedge sys_clk);
      wr(ACD_OFS_DRIVE_HEAD, {3'b101, drive_number, 4'h5});
      rd(ACD_OFS_DRIVE_ADDRESS, rb(dh, 1'b1) & 8'h7F);
      wait_idle();
      repeat (5) @(negedge sys_clk);
      rd(ACD_OFS_DRIVE_ADDRESS, rb(dh, 1'b0) & 8'h7F);
      clr();
      $display("test write gate done");
      delay = 60;
      q.push_back({2'd0, 8'hCD, 2'd3, 4'hA});
      wr(ACD_OFS_COMMAND, 8'hCD);
      repeat (5) @(negedge sys_clk);
      wr(ACD_OFS_DEVICE_CONTROL, 8'h04);
      repeat (20) @(negedge sys_clk);
      `CHK("soft reset", 1'b1, soft_reset_active & busy_flag)
      wr(ACD_OFS_DEVICE_CONTROL, 8'h00);
      repeat (90) @(negedge sys_clk);
      `CHK("reinit busy", 1'b1, busy_flag)
      wait_idle();
      `CHK("reset done", 1'b0, soft_reset_active)
      rd(ACD_OFS_DRIVE_ADDRESS, rb(dh, 1'b0) & 8'h7F);
      repeat (3) @(negedge sys_clk);
      $display("test soft reset done");
      end_of_test();
   end
endmodule // tb
